// ### scw_status_wake.sv
// status register latch, clearing, fault/status output and local wake logic
`timescale 1ns/1ps

module scw_status_wake
    import scw_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic standby_select_n,
    input wire logic mode_select,
    input wire logic wake_pin,
    input wire logic [1:0] op_mode,
    input wire logic readout_enabled,
    input wire logic remote_wake_evt,
    input wire logic [FAULT_W-1:0] fault_cond,
    input wire logic power_up_cond,
    output logic fault_status_out_n,
    output logic rxd_wake_n,
    output logic rxen_wake_n,
    output logic wake_flag_n,
    output logic local_wake_evt,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [2:0] pin_meta_q;
    logic [2:0] pin_sync_q;
    logic sbsel_s;
    logic msel_s;
    logic wake_s;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_meta_q <= 3'h7;
            pin_sync_q <= 3'h7;
        end else begin
            pin_meta_q <= {wake_pin, mode_select, standby_select_n};
            pin_sync_q <= pin_meta_q;
        end
    end

    assign sbsel_s = pin_sync_q[0];
    assign msel_s = pin_sync_q[1];
    assign wake_s = pin_sync_q[2];

    // ************************************************************
    // host command decode
    // ************************************************************
    function automatic scw_cmd_t cmd_of(input logic sbsel, input logic msel);
        scw_cmd_t c;
        c = cmd_normal;
        unique case ({sbsel, msel})
            2'b11: c = cmd_normal;
            2'b10: c = cmd_listen_only;
            2'b01: c = enter_sleep_command;
            2'b00: c = cmd_standby;
        endcase
        return c;
    endfunction : cmd_of

    scw_cmd_t host_cmd;
    scw_mode_t mode;
    logic low_power;

    assign host_cmd = cmd_of(sbsel_s, msel_s);
    assign mode = scw_mode_t'(op_mode);
    // wake bits may be set only in low power or under the go-to-sleep command
    assign low_power = (mode == standby_low_power) || (mode == sleep_low_power)
        || (host_cmd == enter_sleep_command);

    // ************************************************************
    // software registers
    // ************************************************************
    logic [15:0] filter_q;
    logic resp_q;
    logic req;
    logic wr_go;

    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~resp_q;
    assign wr_go = avs_write & resp_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            resp_q <= 1'b0;
        end else begin
            resp_q <= req & ~resp_q;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            filter_q <= FILTER_RESET;
        end else if (wr_go && avs_address == ADDR_FILTER) begin
            // a zero count would accept every spike, so keep at least one cycle
            filter_q <= (avs_writedata[15:0] == 16'h0000) ? 16'h0001 : avs_writedata[15:0];
        end
    end

    // ************************************************************
    // local wake detector
    // ************************************************************
    logic [15:0] filt_cnt_q;
    logic level_q;
    logic init_q;
    logic wake_evt;

    // runs in every mode; mode gating happens only at the register
    assign wake_evt = init_q && (wake_s != level_q) && (filt_cnt_q + 16'h0001 >= filter_q);
    assign local_wake_evt = wake_evt;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            init_q <= 1'b0;
            level_q <= 1'b1;
            filt_cnt_q <= 16'h0000;
        end else begin
            init_q <= 1'b1;
            if (!init_q) begin
                // take the synchroniser's reset level of 1, not yet the pin, without treating it as an edge
                level_q <= wake_s;
                filt_cnt_q <= 16'h0000;
            end else if (wake_s == level_q) begin
                filt_cnt_q <= 16'h0000;
            end else if (wake_evt) begin
                level_q <= wake_s;
                filt_cnt_q <= 16'h0000;
            end else begin
                filt_cnt_q <= filt_cnt_q + 16'h0001;
            end
        end
    end

    // ************************************************************
    // serial readout
    // ************************************************************
    logic msel_d1_q;
    logic msel_fall;
    logic [3:0] idx_q;
    logic ser_q;
    logic clr_start;
    logic [1:0] mode_q;
    logic norm_entry;
    logic [15:0] stat_q;
    logic [15:0] stat_view;

    assign msel_fall = msel_d1_q & ~msel_s;
    assign norm_entry = (mode == normal_operation) && (mode_q != 2'(normal_operation))
        && (host_cmd == cmd_normal);
    assign clr_start = norm_entry || (readout_enabled && msel_fall && idx_q == LAST_BIT);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            msel_d1_q <= 1'b1;
            mode_q <= 2'(normal_operation);
        end else begin
            msel_d1_q <= msel_s;
            mode_q <= op_mode;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idx_q <= 4'h0;
            ser_q <= 1'b1;
        end else if (!readout_enabled) begin
            // an aborted readout restarts at bit 0 next time, nothing cleared
            idx_q <= 4'h0;
            ser_q <= 1'b1;
        end else if (msel_fall) begin
            ser_q <= stat_view[idx_q];
            idx_q <= idx_q + 4'h1;
        end
    end

    // ************************************************************
    // status register
    // ************************************************************
    logic [15:0] stat_d;
    logic [15:0] stat_clr;
    logic wake_set;

    // latched bits that a clearing sequence may release
    assign stat_clr = {3'b000, 1'b1, 1'b0, ~fault_cond, ~power_up_cond, 1'b0, 1'b1, 1'b1};
    assign wake_set = wake_evt && low_power;

    always_comb begin
        stat_d = stat_q;
        if (clr_start) begin
            stat_d = stat_q | stat_clr;
        end
        // sets win over a clear in the same cycle
        stat_d[BIT_FAULT_HI:BIT_FAULT_LO] = stat_d[BIT_FAULT_HI:BIT_FAULT_LO] & ~fault_cond;
        if (power_up_cond) begin
            stat_d[BIT_POWER_UP] = 1'b0;
        end
        if (wake_set) begin
            stat_d[BIT_LOCAL_WAKE] = 1'b0;
        end
        if (remote_wake_evt && low_power) begin
            stat_d[BIT_REMOTE_WAKE] = 1'b0;
            stat_d[BIT_WAKE_SRC] = 1'b0;
        end
        stat_d[BIT_RESERVED] = 1'b1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stat_q <= STAT_RESET;
        end else begin
            stat_q <= stat_d;
        end
    end

    // summary, indication and parity bits are derived, not stored
    always_comb begin
        stat_view = stat_q;
        stat_view[BIT_ERROR] = &stat_q[BIT_FAULT_HI:BIT_FAULT_LO];
        stat_view[BIT_MODE_IND] = msel_s;
        stat_view[BIT_STBY_IND] = sbsel_s;
        stat_view[BIT_PARITY] = 1'b0;
        stat_view[BIT_PARITY] = ^stat_view[14:0];
    end

    // ************************************************************
    // fault/status output and wake flag
    // ************************************************************
    logic out_d;
    logic out_q;

    assign wake_flag_n = stat_q[BIT_LOCAL_WAKE] & stat_q[BIT_REMOTE_WAKE];

    // chosen from the host command even when the mode differs
    always_comb begin
        out_d = 1'b1;
        if (readout_enabled) begin
            out_d = msel_fall ? stat_view[idx_q] : ser_q;
        end else begin
            unique case (host_cmd)
                cmd_normal: out_d = stat_view[BIT_ERROR];
                cmd_listen_only: out_d = wake_flag_n ? stat_view[BIT_ERROR] : stat_q[BIT_WAKE_SRC];
                enter_sleep_command: out_d = wake_flag_n;
                cmd_standby: out_d = wake_flag_n;
            endcase
        end
    end

    // only latched bits, readout_enabled and the synced mode pins drive it, so it cannot toggle by itself
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_q <= 1'b1;
        end else begin
            out_q <= out_d;
        end
    end

    assign fault_status_out_n = out_q;
    assign rxd_wake_n = ~(low_power && !wake_flag_n);
    assign rxen_wake_n = rxd_wake_n;

    // ************************************************************
    // bus read data
    // ************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !resp_q) begin
            unique case (avs_address)
                ADDR_STATUS: avs_readdata <= {16'h0000, stat_view};
                ADDR_STATE: avs_readdata <= {21'h0, host_cmd, 1'b0, readout_enabled, idx_q, out_q, wake_flag_n};
                ADDR_FILTER: avs_readdata <= {16'h0000, filter_q};
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    // independent count of how long the synced wake level has held
    logic wake_prev_q;
    logic [15:0] wake_hold_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wake_prev_q <= 1'b1;
            wake_hold_q <= 16'h0000;
        end else begin
            wake_prev_q <= wake_s;
            if (wake_s != wake_prev_q) begin
                wake_hold_q <= 16'h0000;
            end else if (wake_hold_q != 16'hffff) begin
                wake_hold_q <= wake_hold_q + 16'h0001;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_full_read_clears;
        readout_enabled && msel_fall && idx_q == 4'hf |-> clr_start ##1 idx_q == 4'h0;
    endproperty
    a_full_read_clears: assert property (p_full_read_clears) else $error("full readout did not clear");

    property p_no_clear_keeps;
        !clr_start |=> ((~$past(stat_q)) & stat_q) == 16'h0000;
    endproperty
    a_no_clear_keeps: assert property (p_no_clear_keeps) else $error("bit released without clear");

    property p_cause_holds;
        clr_start && fault_cond[0] |=> !stat_q[BIT_FAULT_LO];
    endproperty
    a_cause_holds: assert property (p_cause_holds) else $error("bit cleared with cause present");

    property p_shift_bit;
        readout_enabled && msel_fall && !clr_start |=> fault_status_out_n == $past(stat_view[idx_q]);
    endproperty
    a_shift_bit: assert property (p_shift_bit) else $error("wrong serial bit");

    property p_sleep_shows_flag;
        !readout_enabled && !sbsel_s |=> fault_status_out_n == $past(wake_flag_n);
    endproperty
    a_sleep_shows_flag: assert property (p_sleep_shows_flag) else $error("flag not shown");

    property p_src_shown;
        !readout_enabled && sbsel_s && !msel_s && !wake_flag_n |=> fault_status_out_n == $past(stat_q[BIT_WAKE_SRC]);
    endproperty
    a_src_shown: assert property (p_src_shown) else $error("wake source not shown");

    property p_local_sets;
        wake_evt && low_power |=> !stat_q[BIT_LOCAL_WAKE] && !wake_flag_n;
    endproperty
    a_local_sets: assert property (p_local_sets) else $error("local wake not latched");

    property p_ignored;
        wake_evt && !low_power |=> !(!stat_q[BIT_LOCAL_WAKE] && $past(stat_q[BIT_LOCAL_WAKE]));
    endproperty
    a_ignored: assert property (p_ignored) else $error("wake latched outside low power");

    property p_src_kept;
        wake_evt && !remote_wake_evt |=> stat_q[BIT_WAKE_SRC] || !$past(stat_q[BIT_WAKE_SRC]);
    endproperty
    a_src_kept: assert property (p_src_kept) else $error("local wake touched source bit");

    property p_filter_len;
        wake_evt && filter_q > 16'h0001 |-> wake_s == wake_prev_q
            && {1'b0, wake_hold_q} + 17'h00002 >= {1'b0, filter_q};
    endproperty
    a_filter_len: assert property (p_filter_len) else $error("wake accepted too early");

    property p_rx_flag;
        low_power && !wake_flag_n |-> !rxd_wake_n && !rxen_wake_n;
    endproperty
    a_rx_flag: assert property (p_rx_flag) else $error("receive pins miss wake flag");

    c_full_read: cover property (readout_enabled && msel_fall && idx_q == 4'hf);
    c_local_wake: cover property (wake_set);
    c_norm_entry: cover property (norm_entry);
    c_abort: cover property ($fell(readout_enabled) && idx_q != 4'h0);

endmodule : scw_status_wake

// ### scw_pkg.sv
// constants and types shared by the status clear and local wake block
package scw_pkg;

    // ************************************************************
    // status register layout, active-low bits
    // ************************************************************
    localparam int STAT_W = 16;
    localparam int BIT_LOCAL_WAKE = 0;
    localparam int BIT_REMOTE_WAKE = 1;
    localparam int BIT_RESERVED = 2;
    localparam int BIT_POWER_UP = 3;
    localparam int BIT_FAULT_LO = 4;
    localparam int BIT_FAULT_HI = 10;
    localparam int FAULT_W = 7;
    localparam int BIT_ERROR = 11;
    localparam int BIT_WAKE_SRC = 12;
    localparam int BIT_MODE_IND = 13;
    localparam int BIT_STBY_IND = 14;
    localparam int BIT_PARITY = 15;
    // all clear except the power-up bit, which is set after reset
    localparam logic [15:0] STAT_RESET = 16'hfff7;
    localparam logic [3:0] LAST_BIT = 4'hf;

    // ************************************************************
    // register map, byte addresses
    // ************************************************************
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_STATE = 4'h4;
    localparam logic [3:0] ADDR_FILTER = 4'h8;
    localparam int ST_WAKE_FLAG = 0;
    localparam int ST_FAULT_OUT = 1;
    localparam int ST_IDX_LO = 2;
    localparam int ST_READOUT = 6;
    localparam int ST_CMD_LO = 8;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_NS = 50;
    localparam int WAKE_PULSE_FILTER_NS = 10000;
    localparam int WAKE_FILTER_CYC = (WAKE_PULSE_FILTER_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [15:0] FILTER_RESET = 16'(WAKE_FILTER_CYC);

    // ************************************************************
    // modes and host commands
    // ************************************************************
    typedef enum logic [1:0] {
        normal_operation = 2'b00,
        listen_only_operation = 2'b01,
        standby_low_power = 2'b10,
        sleep_low_power = 2'b11
    } scw_mode_t;

    typedef enum logic [2:0] {
        cmd_normal = 3'b000,
        cmd_listen_only = 3'b001,
        enter_sleep_command = 3'b010,
        cmd_standby = 3'b011
    } scw_cmd_t;

endpackage : scw_pkg

// ### scw_host_model.sv
// host microcontroller model: drives the mode pins and samples the status output
`timescale 1ns/1ps
module scw_host_model (
    input wire logic clk,
    input wire logic fault_status_out_n,
    output logic standby_select_n,
    output logic mode_select
);
    // ************************************************************
    // host command pins
    // ************************************************************
    initial begin
        standby_select_n = 1'h1;
        mode_select = 1'h1;
    end
    task automatic set_cmd(input logic ssn, input logic ms);
        @(posedge clk);
        standby_select_n <= ssn;
        mode_select <= ms;
    endtask : set_cmd
    // ************************************************************
    // serial readout
    // ************************************************************
    // phases are held well past the pin synchroniser so no shift is lost
    task automatic shift_bits(input int n, output logic [15:0] bits);
        bits = 16'hffff;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            mode_select <= 1'h0;
            repeat (5) @(posedge clk);
            @(negedge clk);
            bits[i] = fault_status_out_n;
            @(posedge clk);
            mode_select <= 1'h1;
            repeat (4) @(posedge clk);
        end
    endtask : shift_bits
endmodule : scw_host_model

// ### scw_status_wake_tb_top.sv
// self-checking bench for the status clear and local wake block
`timescale 1ns/1ps
module scw_status_wake_tb_top
    import scw_pkg::*;
;
    // ************************************************************
    // signals
    // ************************************************************
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic wake_pin = 1'h1;
    logic [1:0] op_mode = 2'h1;
    logic readout_enabled = 1'h0;
    logic remote_wake_evt = 1'h0;
    logic [FAULT_W-1:0] fault_cond = 7'h0;
    logic power_up_cond = 1'h1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, standby_select_n, mode_select, fault_status_out_n;
    logic rxd_wake_n, rxen_wake_n, wake_flag_n, local_wake_evt;
    int num_errors = 0;
    int n_checks = 0;
    int evt_cnt = 0;
    int unsigned cyc = 0;
    logic [31:0] rdat;
    logic [15:0] b, e;
    logic [6:0] f, g, flt;
    logic lw, rw, src, pu;

    scw_host_model scw_host_model_i (.clk(clk), .fault_status_out_n(fault_status_out_n),
        .standby_select_n(standby_select_n), .mode_select(mode_select));
    scw_status_wake scw_status_wake_i (.clk(clk), .rst(rst), .standby_select_n(standby_select_n),
        .mode_select(mode_select), .wake_pin(wake_pin), .op_mode(op_mode), .readout_enabled(readout_enabled),
        .remote_wake_evt(remote_wake_evt), .fault_cond(fault_cond), .power_up_cond(power_up_cond),
        .fault_status_out_n(fault_status_out_n), .rxd_wake_n(rxd_wake_n), .rxen_wake_n(rxen_wake_n),
        .wake_flag_n(wake_flag_n), .local_wake_evt(local_wake_evt), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

    always #25 clk = ~clk;
    always @(posedge clk) begin
        if (local_wake_evt === 1'h1) begin
            evt_cnt <= evt_cnt + 1;
        end
    end
    // ************************************************************
    // helpers
    // ************************************************************
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            end_sim();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // outputs are looked at on the falling edge, away from the update edge
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : wt
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_read <= ~wr;
        avs_write <= wr;
        // request stands until waitrequest is seen low at a rising edge
        @(posedge clk);
        while (avs_waitrequest !== 1'h0) begin
            @(posedge clk);
        end
        rd = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
    endtask : bus
    // active-low view of bits 0..12; bits 13 and 14 follow live pins, and only bits 14 and 15 are checked apart
    function automatic logic [15:0] stat_exp(input logic l, input logic r, input logic s, input logic p,
        input logic [6:0] fc);
        logic [15:0] v;
        v = 16'hffff;
        v[BIT_LOCAL_WAKE] = ~l;
        v[BIT_REMOTE_WAKE] = ~r;
        v[BIT_POWER_UP] = ~p;
        v[BIT_FAULT_HI:BIT_FAULT_LO] = ~fc;
        v[BIT_ERROR] = ~|fc;
        v[BIT_WAKE_SRC] = ~s;
        return v & 16'h1fff;
    endfunction : stat_exp
    task automatic chk_stat();
        logic [31:0] r;
        bus(1'h0, ADDR_STATUS, 32'h0, r);
        check(r[15:0] & 16'h1fff, stat_exp(lw, rw, src, pu, flt));
    endtask : chk_stat
    task automatic norm_clear();
        @(posedge clk);
        op_mode <= 2'h1;
        wt(3);
        @(posedge clk);
        op_mode <= 2'h0;
        wt(3);
    endtask : norm_clear
    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        void'($urandom(84680));
        {lw, rw, src, pu, flt} = {4'h1, 7'h0};
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        wt(2);
        chk_stat();
        bus(1'h1, ADDR_STATUS, 32'h0, rdat);
        chk_stat();
        bus(1'h0, ADDR_FILTER, 32'h0, rdat);
        check(rdat, {16'h0, FILTER_RESET});
        bus(1'h1, ADDR_FILTER, 32'h0, rdat);
        bus(1'h0, ADDR_FILTER, 32'h0, rdat);
        check(rdat, 32'h1);
        bus(1'h0, 4'hc, 32'h0, rdat);
        check(rdat, 32'h0);
        bus(1'h1, ADDR_FILTER, 32'h3, rdat);
        wt(0);
        check(fault_status_out_n, 1'h1);
        check(wake_flag_n, 1'h1);
        norm_clear();
        chk_stat();
        @(posedge clk);
        power_up_cond <= 1'h0;
        pu = 1'h0;
        norm_clear();
        chk_stat();
        $display("test registers and normal entry done");
        for (int i = 0; i < 4; i++) begin
            f = 7'($urandom_range(127, 1));
            g = f & 7'($urandom);
            @(posedge clk);
            fault_cond <= f;
            op_mode <= 2'h3;
            flt = f;
            wt(6);
            check(fault_status_out_n, 1'h0);
            chk_stat();
            scw_host_model_i.set_cmd(1'h1, 1'h0);
            wt(6);
            check(fault_status_out_n, 1'h0);
            scw_host_model_i.set_cmd(1'h1, 1'h1);
            @(posedge clk);
            fault_cond <= g;
            wt(10);
            check(fault_status_out_n, 1'h0);
            norm_clear();
            flt = g;
            chk_stat();
            wt(0);
            check(fault_status_out_n, 1'(g == 7'h0));
            @(posedge clk);
            fault_cond <= 7'h0;
            flt = 7'h0;
            norm_clear();
            wt(20);
            check(fault_status_out_n, 1'h1);
        end
        $display("test error indication done");
        @(posedge clk);
        wake_pin <= 1'h0;
        wt(12);
        check(evt_cnt, 1);
        chk_stat();
        @(posedge clk);
        wake_pin <= 1'h1;
        repeat (2) @(posedge clk);
        wake_pin <= 1'h0;
        wt(12);
        check(evt_cnt, 1);
        scw_host_model_i.set_cmd(1'h0, 1'h0);
        @(posedge clk);
        op_mode <= 2'h2;
        wt(6);
        check(fault_status_out_n, 1'h1);
        @(posedge clk);
        wake_pin <= 1'h1;
        wt(12);
        lw = 1'h1;
        check(evt_cnt, 2);
        chk_stat();
        wt(0);
        check(wake_flag_n, 1'h0);
        check(rxd_wake_n, 1'h0);
        check(rxen_wake_n, 1'h0);
        check(fault_status_out_n, 1'h0);
        bus(1'h0, ADDR_STATE, 32'h0, rdat);
        check(rdat[ST_WAKE_FLAG], 1'h0);
        scw_host_model_i.set_cmd(1'h1, 1'h0);
        @(posedge clk);
        op_mode <= 2'h1;
        wt(6);
        check(fault_status_out_n, 1'h1);
        check(rxd_wake_n, 1'h1);
        scw_host_model_i.set_cmd(1'h0, 1'h1);
        @(posedge clk);
        op_mode <= 2'h3;
        wt(6);
        @(posedge clk);
        remote_wake_evt <= 1'h1;
        @(posedge clk);
        remote_wake_evt <= 1'h0;
        wt(4);
        {rw, src} = 2'h3;
        chk_stat();
        scw_host_model_i.set_cmd(1'h1, 1'h0);
        @(posedge clk);
        op_mode <= 2'h1;
        wt(6);
        check(fault_status_out_n, 1'h0);
        $display("test wake done");
        scw_host_model_i.set_cmd(1'h1, 1'h1);
        e = stat_exp(lw, rw, src, pu, flt);
        @(posedge clk);
        readout_enabled <= 1'h1;
        wt(2);
        // stop right after the set wake source bit, so the fault/status output that follows differs from it
        scw_host_model_i.shift_bits(13, b);
        check(b[12:0], e[12:0]);
        @(posedge clk);
        readout_enabled <= 1'h0;
        wt(4);
        chk_stat();
        wt(0);
        check(fault_status_out_n, 1'h1);
        @(posedge clk);
        readout_enabled <= 1'h1;
        wt(2);
        scw_host_model_i.shift_bits(16, b);
        check(b & 16'h1fff, e);
        check(b[BIT_STBY_IND], 1'h1);
        check(b[BIT_PARITY], ^b[14:0]);
        {lw, rw, src} = 3'h0;
        scw_host_model_i.shift_bits(1, b);
        check(b[BIT_LOCAL_WAKE], 1'h1);
        @(posedge clk);
        readout_enabled <= 1'h0;
        wt(4);
        chk_stat();
        wt(0);
        check(wake_flag_n, 1'h1);
        $display("test readout done");
        end_sim();
    end
endmodule : scw_status_wake_tb_top
